// ### rtl/mpo_output_stage.sv
// Summary of operation
// - drive select 00 both pulse, 01 low floats, 10 high floats, 11 both float
// - high side, polarity clear: duty high normal, low motor, starts high
// - high side, polarity set: duty low normal, high motor, starts low
// - low side, polarity clear: duty high normal, low motor, starts low
// - low side, polarity set: duty low normal, high motor, starts high
// - six override bits 5..0 UH UL VH VL WH WL combine with outputs
// - a zero duty value gives no pulses on that output
// - motor mode: with polarity clear, high sides start low, low sides start high
// - combine select: AND, OR, XOR, or AND with disabled port floating
// - overrides act only while force mode is enabled
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
module mpo_output_stage #(
	parameter int unsigned VALUE_WIDTH = mpo_pkg::VALUE_WIDTH,
	parameter int unsigned PIN_COUNT = mpo_pkg::PIN_COUNT
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// gate driver pins, bit 5..0 = UH UL VH VL WH WL
	output logic [PIN_COUNT-1:0] pwm_pin,
	output logic [PIN_COUNT-1:0] pwm_pin_oe_n
);

	localparam logic [3:0] SEL_NONE = 4'hF;
	localparam logic [3:0] SEL_CONTROL = 4'h0;
	localparam logic [3:0] SEL_DRIVE = 4'h1;
	localparam logic [3:0] SEL_OVERRIDE = 4'h2;
	localparam logic [3:0] SEL_PERIOD = 4'h3;
	localparam logic [3:0] SEL_DUTY = 4'h4;
	localparam logic [3:0] SEL_COUNTER = 4'h5;

	logic [15:0] control;
	logic [15:0] port_drive_mode;
	logic [7:0] output_override;
	logic [VALUE_WIDTH-1:0] pwm_period;
	logic [VALUE_WIDTH-1:0] duty [PIN_COUNT];
	logic [VALUE_WIDTH-1:0] count;
	mpo_pkg::mpo_state_type state;
	mpo_pkg::mpo_state_type next_state;

	logic setup_phase;
	logic write_taken;
	logic [3:0] access_sel;
	logic [2:0] access_duty;
	logic [31:0] next_prdata;
	logic [PIN_COUNT-1:0] active;
	logic [1:0] drive_sel;
	logic high_drive_on;
	logic low_drive_on;
	logic running;

	// register selector for an address, shared by read and write paths
	function automatic logic [3:0] reg_select(input logic [31:0] addr);
		unique case (addr)
			mpo_pkg::CONTROL_ADDR: reg_select = SEL_CONTROL;
			mpo_pkg::PORT_DRIVE_MODE_ADDR: reg_select = SEL_DRIVE;
			mpo_pkg::OUTPUT_OVERRIDE_ADDR: reg_select = SEL_OVERRIDE;
			mpo_pkg::PWM_PERIOD_ADDR: reg_select = SEL_PERIOD;
			mpo_pkg::DUTY_U_HIGH_ADDR, mpo_pkg::DUTY_V_HIGH_ADDR,
			mpo_pkg::DUTY_W_HIGH_ADDR, mpo_pkg::DUTY_U_LOW_ADDR,
			mpo_pkg::DUTY_V_LOW_ADDR, mpo_pkg::DUTY_W_LOW_ADDR: reg_select = SEL_DUTY;
			mpo_pkg::COUNTER_ADDR: reg_select = SEL_COUNTER;
			default: reg_select = SEL_NONE;
		endcase
	endfunction

	// duty register address to pin index (0 = UH .. 5 = WL)
	function automatic logic [2:0] duty_index(input logic [31:0] addr);
		unique case (addr)
			mpo_pkg::DUTY_U_HIGH_ADDR: duty_index = 3'h0;
			mpo_pkg::DUTY_U_LOW_ADDR: duty_index = 3'h1;
			mpo_pkg::DUTY_V_HIGH_ADDR: duty_index = 3'h2;
			mpo_pkg::DUTY_V_LOW_ADDR: duty_index = 3'h3;
			mpo_pkg::DUTY_W_HIGH_ADDR: duty_index = 3'h4;
			default: duty_index = 3'h5;
		endcase
	endfunction

	// byte-lane merge; pstrb all ones on a full word write
	function automatic logic [15:0] lane_merge(input logic [15:0] old_value,
			input logic [31:0] wdata, input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] merged;
		merged = old_value;
		if (strb[0]) begin
			merged[7:0] = wdata[7:0];
		end
		if (strb[1]) begin
			merged[15:8] = wdata[15:8];
		end
		lane_merge = merged & mask;
	endfunction

	assign setup_phase = psel & ~penable;
	assign write_taken = psel & penable & pready & pwrite & ~pslverr;
	assign access_sel = reg_select(paddr);
	assign access_duty = duty_index(paddr);

	// apb answer: zero-wait access phase, data captured in setup
	always_comb begin
		next_prdata = 32'h0000_0000;
		unique case (access_sel)
			SEL_CONTROL: next_prdata[15:0] = control;
			SEL_DRIVE: next_prdata[15:0] = port_drive_mode;
			SEL_OVERRIDE: next_prdata[7:0] = output_override;
			SEL_PERIOD: next_prdata[VALUE_WIDTH-1:0] = pwm_period;
			SEL_DUTY: next_prdata[VALUE_WIDTH-1:0] = duty[access_duty];
			SEL_COUNTER: next_prdata[VALUE_WIDTH-1:0] = count;
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup_phase;
			// unmapped addresses and counter writes answer with an error
			pslverr <= setup_phase & ((access_sel == SEL_NONE) |
				(pwrite & (access_sel == SEL_COUNTER)));
			prdata <= (setup_phase & ~pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control <= mpo_pkg::CONTROL_RESET;
		end else if (write_taken && access_sel == SEL_CONTROL) begin
			control <= lane_merge(control, pwdata, pstrb, mpo_pkg::CTRL_WRITE_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_drive_mode <= mpo_pkg::DRIVE_RESET;
		end else if (write_taken && access_sel == SEL_DRIVE) begin
			port_drive_mode <= lane_merge(port_drive_mode, pwdata, pstrb,
				mpo_pkg::DRIVE_WRITE_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_override <= mpo_pkg::OVERRIDE_RESET;
		end else if (write_taken && access_sel == SEL_OVERRIDE && pstrb[0]) begin
			output_override <= pwdata[7:0] & mpo_pkg::OVERRIDE_WRITE_MASK;
		end
	end

	// no range check: a period at or below 0x0010 just runs short cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_period <= mpo_pkg::PERIOD_RESET;
		end else if (write_taken && access_sel == SEL_PERIOD) begin
			pwm_period <= lane_merge(pwm_period, pwdata, pstrb, 16'hFFFF);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				duty[i] <= mpo_pkg::DUTY_RESET;
			end
		end else if (write_taken && access_sel == SEL_DUTY) begin
			duty[access_duty] <= lane_merge(duty[access_duty], pwdata, pstrb,
				16'hFFFF);
		end
	end

	// run state follows the run bit; stopping returns pins to rest levels
	always_comb begin
		unique case (state)
			mpo_pkg::MPO_IDLE: next_state = control[mpo_pkg::CTRL_RUN_BIT] ?
				mpo_pkg::MPO_RUN : mpo_pkg::MPO_IDLE;
			mpo_pkg::MPO_RUN: next_state = control[mpo_pkg::CTRL_RUN_BIT] ?
				mpo_pkg::MPO_RUN : mpo_pkg::MPO_IDLE;
			default: next_state = mpo_pkg::MPO_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= mpo_pkg::MPO_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign running = (state == mpo_pkg::MPO_RUN);

	// simple up counter 0 .. period-1 to give the duty values a waveform
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (!running || count + 1'b1 >= pwm_period) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// active while the counter is below the duty; zero duty never is
	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			active[PIN_COUNT-1-i] = count < duty[i];
		end
	end

	assign drive_sel = port_drive_mode[mpo_pkg::DRIVE_SEL_LSB +: 2];
	assign high_drive_on = (drive_sel == mpo_pkg::DRIVE_BOTH) ||
		(drive_sel == mpo_pkg::DRIVE_HIGH_ONLY);
	assign low_drive_on = (drive_sel == mpo_pkg::DRIVE_BOTH) ||
		(drive_sel == mpo_pkg::DRIVE_LOW_ONLY);

	for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
		localparam bit HIGH = mpo_pkg::HIGH_SIDE_PINS[p];
		mpo_pin_cell #(
			.IS_HIGH_SIDE(HIGH)
		) u_cell (
			.pclk(pclk),
			.presetn(presetn),
			.running(running),
			.active(active[p]),
			.invert(port_drive_mode[p]),
			.motor(control[mpo_pkg::CTRL_MOTOR_BIT]),
			.drive_on(HIGH ? high_drive_on : low_drive_on),
			.force_en(control[mpo_pkg::CTRL_FORCE_EN_BIT]),
			.force_sel(control[mpo_pkg::CTRL_FORCE_SEL_LSB +: 2]),
			.override(output_override[p]),
			.pin(pwm_pin[p]),
			.pin_oe_n(pwm_pin_oe_n[p])
		);
	end

	// checks
	logic ctl_force;
	logic ctl_motor;
	logic [1:0] ctl_combine;
	assign ctl_force = control[mpo_pkg::CTRL_FORCE_EN_BIT];
	assign ctl_motor = control[mpo_pkg::CTRL_MOTOR_BIT];
	assign ctl_combine = control[mpo_pkg::CTRL_FORCE_SEL_LSB +: 2];

	sequence s_idle_normal;
		!running && !ctl_force && !ctl_motor && port_drive_mode[5:0] == 6'h00;
	endsequence

	sequence s_idle_motor;
		!running && !ctl_force && ctl_motor && port_drive_mode[5:0] == 6'h00;
	endsequence

	// stopped, normal mode, plain polarity; force mode left open
	sequence s_idle_plain;
		!running && !ctl_motor && port_drive_mode[5:0] == 6'h00;
	endsequence

	a_both_float: assert property (@(posedge pclk) disable iff (!presetn)
		drive_sel == mpo_pkg::DRIVE_NONE && !ctl_force |=> pwm_pin_oe_n == 6'h3F)
		else $error("drive none did not float all pins");

	a_low_floats: assert property (@(posedge pclk) disable iff (!presetn)
		drive_sel == mpo_pkg::DRIVE_HIGH_ONLY && !ctl_force
		|=> pwm_pin_oe_n == 6'h15)
		else $error("high-only drive wrong enables");

	a_high_floats: assert property (@(posedge pclk) disable iff (!presetn)
		drive_sel == mpo_pkg::DRIVE_LOW_ONLY && !ctl_force
		|=> pwm_pin_oe_n == 6'h2A)
		else $error("low-only drive wrong enables");

	a_drive_both: assert property (@(posedge pclk) disable iff (!presetn)
		drive_sel == mpo_pkg::DRIVE_BOTH && !ctl_force |=> pwm_pin_oe_n == 6'h00)
		else $error("both-side drive left a pin floating");

	a_rest_normal: assert property (@(posedge pclk) disable iff (!presetn)
		s_idle_normal |=> pwm_pin == 6'h2A)
		else $error("normal rest levels wrong");

	a_rest_motor: assert property (@(posedge pclk) disable iff (!presetn)
		s_idle_motor |=> pwm_pin == 6'h15)
		else $error("motor rest levels wrong");

	a_rest_invert: assert property (@(posedge pclk) disable iff (!presetn)
		!running && !ctl_force && !ctl_motor && port_drive_mode[5:0] == 6'h3F
		|=> pwm_pin == 6'h15)
		else $error("inverted rest levels wrong");

	a_float_data: assert property (@(posedge pclk) disable iff (!presetn)
		(drive_sel == mpo_pkg::DRIVE_NONE) ##0 s_idle_normal |=> pwm_pin == 6'h2A)
		else $error("floated pins lost their data level");

	a_duty_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		running && !ctl_force && !ctl_motor && !port_drive_mode[1] && count < duty[4]
		|=> pwm_pin[1])
		else $error("wh not high during duty");

	a_pulse_off: assert property (@(posedge pclk) disable iff (!presetn)
		running && !ctl_force && !ctl_motor && !port_drive_mode[1] && count >= duty[4]
		|=> !pwm_pin[1])
		else $error("wh high outside duty");

	a_low_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		running && !ctl_force && !ctl_motor && !port_drive_mode[4] && count < duty[1]
		|=> pwm_pin[4])
		else $error("ul not high during duty");

	a_zero_duty: assert property (@(posedge pclk) disable iff (!presetn)
		running && !ctl_force && !ctl_motor && !port_drive_mode[5] && duty[0] == 16'h0000
		|=> !pwm_pin[5])
		else $error("pulse with zero duty");

	a_force_and: assert property (@(posedge pclk) disable iff (!presetn)
		ctl_force && ctl_combine == mpo_pkg::FORCE_AND
		|=> (pwm_pin & ~$past(output_override[5:0])) == 6'h00)
		else $error("and with zero override bit not low");

	a_force_or: assert property (@(posedge pclk) disable iff (!presetn)
		ctl_force && ctl_combine == mpo_pkg::FORCE_OR
		|=> (pwm_pin & $past(output_override[5:0])) == $past(output_override[5:0]))
		else $error("or with set override bit not high");

	a_force_xor: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl_force && ctl_combine == mpo_pkg::FORCE_XOR) ##0 s_idle_plain
		|=> pwm_pin == ($past(output_override[5:0]) ^ 6'h2A))
		else $error("xor with override wrong");

	a_force_float: assert property (@(posedge pclk) disable iff (!presetn)
		ctl_force && ctl_combine == mpo_pkg::FORCE_AND_FLOAT
		|=> pwm_pin_oe_n == ~$past(output_override[5:0] & {3{high_drive_on, low_drive_on}}))
		else $error("forced float enables wrong");

	a_forced_data: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl_force && ctl_combine == mpo_pkg::FORCE_AND_FLOAT) ##0 s_idle_plain
		|=> pwm_pin == 6'h2A)
		else $error("forced float changed pin data");

	a_duty_write: assert property (@(posedge pclk) disable iff (!presetn)
		write_taken && paddr == mpo_pkg::DUTY_U_HIGH_ADDR && pstrb == 4'hF
		|=> duty[0] == $past(pwdata[15:0]))
		else $error("duty write lost");

endmodule

// ### rtl/mpo_pin_cell.sv
`timescale 1ns/10ps
module mpo_pin_cell #(
	parameter bit IS_HIGH_SIDE = 1'b1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// waveform
	input wire logic running,
	input wire logic active,
	// configuration
	input wire logic invert,
	input wire logic motor,
	input wire logic drive_on,
	input wire logic force_en,
	input wire logic [1:0] force_sel,
	input wire logic override,
	// pin
	output logic pin,
	output logic pin_oe_n
);

	logic duty_level;
	logic initial_level;
	logic pwm_level;
	logic next_pin;
	logic forced_float;

	always_comb begin
		duty_level = ~invert ^ motor;
		// the two sides rest on opposite levels before start
		initial_level = IS_HIGH_SIDE ? duty_level : ~duty_level;
		pwm_level = running ? (active ? duty_level : ~duty_level) : initial_level;
		forced_float = 1'b0;
		next_pin = pwm_level;
		if (force_en) begin
			unique case (force_sel)
				mpo_pkg::FORCE_AND: next_pin = pwm_level & override;
				mpo_pkg::FORCE_OR: next_pin = pwm_level | override;
				mpo_pkg::FORCE_XOR: next_pin = pwm_level ^ override;
				mpo_pkg::FORCE_AND_FLOAT: begin
					// a floated pin keeps the waveform on its data, only the enable drops
					next_pin = pwm_level;
					forced_float = ~override;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin <= IS_HIGH_SIDE;
			pin_oe_n <= 1'b0;
		end else begin
			pin <= next_pin;
			pin_oe_n <= ~drive_on | forced_float;
		end
	end

endmodule

// ### rtl/mpo_pkg.sv
package mpo_pkg;

	localparam int unsigned ADDR_WIDTH = 32;
	localparam int unsigned DATA_WIDTH = 32;
	localparam int unsigned VALUE_WIDTH = 16;
	localparam int unsigned PIN_COUNT = 6;

	// register byte addresses
	localparam logic [31:0] CONTROL_ADDR = 32'h4000_4000;
	localparam logic [31:0] PORT_DRIVE_MODE_ADDR = 32'h4000_4004;
	localparam logic [31:0] OUTPUT_OVERRIDE_ADDR = 32'h4000_4008;
	localparam logic [31:0] PWM_PERIOD_ADDR = 32'h4000_400C;
	localparam logic [31:0] DUTY_U_HIGH_ADDR = 32'h4000_4010;
	localparam logic [31:0] DUTY_V_HIGH_ADDR = 32'h4000_4014;
	localparam logic [31:0] DUTY_W_HIGH_ADDR = 32'h4000_4018;
	localparam logic [31:0] DUTY_U_LOW_ADDR = 32'h4000_401C;
	localparam logic [31:0] DUTY_V_LOW_ADDR = 32'h4000_4020;
	localparam logic [31:0] DUTY_W_LOW_ADDR = 32'h4000_4024;
	localparam logic [31:0] COUNTER_ADDR = 32'h4000_4038;

	// control register fields
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_FORCE_SEL_LSB = 4;
	localparam int unsigned CTRL_FORCE_EN_BIT = 7;
	localparam int unsigned CTRL_MOTOR_BIT = 15;
	localparam logic [15:0] CTRL_WRITE_MASK = 16'h80B1;

	// port drive mode and output override fields
	localparam int unsigned DRIVE_SEL_LSB = 8;
	localparam logic [15:0] DRIVE_WRITE_MASK = 16'h033F;
	localparam logic [7:0] OVERRIDE_WRITE_MASK = 8'h3F;

	// reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] DRIVE_RESET = 16'h0000;
	localparam logic [7:0] OVERRIDE_RESET = 8'h00;
	localparam logic [15:0] PERIOD_RESET = 16'h0002;
	localparam logic [15:0] DUTY_RESET = 16'h0001;

	// port drive selections
	localparam logic [1:0] DRIVE_BOTH = 2'h0;
	localparam logic [1:0] DRIVE_HIGH_ONLY = 2'h1;
	localparam logic [1:0] DRIVE_LOW_ONLY = 2'h2;
	localparam logic [1:0] DRIVE_NONE = 2'h3;

	// force combine selections
	localparam logic [1:0] FORCE_AND = 2'h0;
	localparam logic [1:0] FORCE_OR = 2'h1;
	localparam logic [1:0] FORCE_XOR = 2'h2;
	localparam logic [1:0] FORCE_AND_FLOAT = 2'h3;

	// pin index order, same as bits 5..0: UH UL VH VL WH WL
	localparam logic [5:0] HIGH_SIDE_PINS = 6'h2A;

	typedef enum logic [1:0] {
		MPO_IDLE = 2'b01,
		MPO_RUN = 2'b10
	} mpo_state_type;

endpackage

// ### sim/mpo_gate_drivers.sv
`timescale 1ns/10ps
// gate driver inputs of the bridge; a released pin is pulled down so the switch stays off
module mpo_gate_drivers (
	// pins from the output stage
	input wire logic [5:0] pwm_pin,
	input wire logic [5:0] pwm_pin_oe_n,
	// level seen by each gate driver
	output logic [5:0] gate_level,
	output logic [5:0] gate_float
);
	assign gate_float = pwm_pin_oe_n;
	assign gate_level = pwm_pin & ~pwm_pin_oe_n;
endmodule

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [3:0] pstrb;
	logic pready;
	logic pslverr;
	logic [5:0] pwm_pin;
	logic [5:0] pwm_pin_oe_n;
	logic [5:0] gate_level;
	logic [5:0] gate_float;
	logic [31:0] rd;
	int num_errors;
	int compares;
	int cnt [6];
	logic [31:0] daddr [6];
	logic [15:0] dval [6];

	mpo_output_stage mpo_output_stage_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwm_pin(pwm_pin), .pwm_pin_oe_n(pwm_pin_oe_n)
	);
	mpo_gate_drivers mpo_gate_drivers_i (
		.pwm_pin(pwm_pin), .pwm_pin_oe_n(pwm_pin_oe_n),
		.gate_level(gate_level), .gate_float(gate_float)
	);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic tally_and_finish();
		if (num_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one apb transfer; waits for pready with a bounded count
	task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
			input logic exp_err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
		rd = prdata;
		check("pslverr", {31'h0, exp_err}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 1'b0);
	endtask

	task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0, 1'b0);
		check(name, exp, rd);
	endtask

	// pins settle within two edges of a register write
	task automatic pinchk(input logic [5:0] mask, input logic [5:0] ep, input logic [5:0] eo);
		repeat (3) @(posedge pclk);
		#1;
		check("pwm_pin", {26'h0, ep & mask}, {26'h0, pwm_pin & mask});
		check("pwm_pin_oe_n", {26'h0, eo}, {26'h0, pwm_pin_oe_n});
		check("gate_level", {26'h0, ep & mask & ~eo}, {26'h0, gate_level & mask});
		check("gate_float", {26'h0, eo}, {26'h0, gate_float});
	endtask

	initial begin
		logic [5:0] f_exp [4];
		logic [5:0] d_oe [4];
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
		num_errors = 0;
		compares = 0;
		f_exp = '{6'h22, 6'h3B, 6'h19, 6'h2A};
		d_oe = '{6'h00, 6'h15, 6'h2A, 6'h3F};
		daddr = '{mpo_pkg::DUTY_U_HIGH_ADDR, mpo_pkg::DUTY_U_LOW_ADDR,
			mpo_pkg::DUTY_V_HIGH_ADDR, mpo_pkg::DUTY_V_LOW_ADDR,
			mpo_pkg::DUTY_W_HIGH_ADDR, mpo_pkg::DUTY_W_LOW_ADDR};
		// zero duty on the first pin on purpose, the others above one
		dval = '{16'h0000, 16'h0003, 16'h0005, 16'h0010, 16'h0002, 16'h001F};
		repeat (4) @(posedge pclk);
		#1;
		check("reset pins", 32'h2A, {26'h0, pwm_pin});
		check("reset enables", 32'h0, {26'h0, pwm_pin_oe_n});
		@(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdchk("duty reset", daddr[i], 32'h0000_0001);
		end
		rdchk("period reset", mpo_pkg::PWM_PERIOD_ADDR, 32'h0000_0002);
		rdchk("drive reset", mpo_pkg::PORT_DRIVE_MODE_ADDR, 32'h0);
		rdchk("override reset", mpo_pkg::OUTPUT_OVERRIDE_ADDR, 32'h0);
		rdchk("counter idle", mpo_pkg::COUNTER_ADDR, 32'h0);
		pinchk(6'h3F, 6'h2A, 6'h00);
		// refused accesses
		apb(32'h4000_4028, 1'b1, 32'h1, 1'b1);
		apb(mpo_pkg::COUNTER_ADDR, 1'b1, 32'h5, 1'b1);
		apb(32'h4000_4050, 1'b0, 32'h0, 1'b1);
		check("unmapped read", 32'h0, rd);
		wr(mpo_pkg::PORT_DRIVE_MODE_ADDR, 32'hFFFF_FFFF);
		rdchk("drive mask", mpo_pkg::PORT_DRIVE_MODE_ADDR, 32'h0000_033F);
		wr(mpo_pkg::PORT_DRIVE_MODE_ADDR, 32'h0000_003F);
		pinchk(6'h3F, 6'h15, 6'h00);
		wr(mpo_pkg::PORT_DRIVE_MODE_ADDR, 32'h0);
		wr(mpo_pkg::CONTROL_ADDR, 32'h0000_8000);
		pinchk(6'h3F, 6'h15, 6'h00);
		rdchk("control motor", mpo_pkg::CONTROL_ADDR, 32'h0000_8000);
		wr(mpo_pkg::CONTROL_ADDR, 32'h0);
		for (int m = 0; m < 4; m++) begin
			wr(mpo_pkg::PORT_DRIVE_MODE_ADDR, 32'(m) << 8);
			pinchk(6'h3F, 6'h2A, d_oe[m]);
		end
		wr(mpo_pkg::PORT_DRIVE_MODE_ADDR, 32'h0);
		wr(mpo_pkg::OUTPUT_OVERRIDE_ADDR, 32'hFF);
		rdchk("override mask", mpo_pkg::OUTPUT_OVERRIDE_ADDR, 32'h3F);
		wr(mpo_pkg::OUTPUT_OVERRIDE_ADDR, 32'h33);
		pinchk(6'h3F, 6'h2A, 6'h00);
		for (int m = 0; m < 4; m++) begin
			wr(mpo_pkg::CONTROL_ADDR, 32'h80 | (32'(m) << 4));
			pinchk(6'h3F, f_exp[m], m == 3 ? 6'h0C : 6'h00);
		end
		wr(mpo_pkg::CONTROL_ADDR, 32'h0);
		pinchk(6'h3F, 6'h2A, 6'h00);
		// running: count active cycles over two whole periods
		for (int i = 0; i < 6; i++) begin
			wr(daddr[i], {16'h0, dval[i]});
			cnt[i] = 0;
		end
		wr(mpo_pkg::PWM_PERIOD_ADDR, 32'h0000_0020);
		wr(mpo_pkg::CONTROL_ADDR, 32'h1);
		repeat (4) @(posedge pclk);
		for (int c = 0; c < 64; c++) begin
			@(posedge pclk);
			#1;
			for (int i = 0; i < 6; i++) begin
				cnt[i] += int'(pwm_pin[5 - i]);
			end
		end
		for (int i = 0; i < 6; i++) begin
			check("active cycles", 32'(2 * dval[i]), 32'(cnt[i]));
		end
		wr(mpo_pkg::CONTROL_ADDR, 32'h0);
		tally_and_finish();
	end
endmodule
